/* prs_pkg.sv */
package prs_pkg;

   // Reset causes applied to the register image
   typedef enum logic [1:0] {RT_EXT, RT_POR, RT_NOBAT, RT_WDT} prs_rst_e;

   // Oscillator periods counted before internal reset release
   localparam int POR_DELAY_PERIODS = 21504;
   localparam int CNT_W             = 15;

   // Own register indices (byte address is four times index)
   localparam logic [7:0] REG_IRQ_STATUS = 8'h00;
   localparam logic [7:0] REG_IRQ_MASK   = 8'h01;
   localparam logic [7:0] REG_SEQ_STATUS = 8'h02;
   localparam logic [7:0] REG_TIMED      = 8'h03;
   localparam logic [7:0] REG_PC_LO      = 8'h04;
   localparam logic [7:0] REG_PC_HI      = 8'h05;

   // Special function register indices
   localparam logic [7:0] SFR_PORT0      = 8'h80;
   localparam logic [7:0] SFR_STACK_PTR  = 8'h81;
   localparam logic [7:0] SFR_DPTR_LO    = 8'h82;
   localparam logic [7:0] SFR_DPTR_HI    = 8'h83;
   localparam logic [7:0] SFR_POWER_CTRL = 8'h87;
   localparam logic [7:0] SFR_TMR_CTRL   = 8'h88;
   localparam logic [7:0] SFR_TMR_MODE   = 8'h89;
   localparam logic [7:0] SFR_TMR0_LO    = 8'h8A;
   localparam logic [7:0] SFR_TMR1_LO    = 8'h8B;
   localparam logic [7:0] SFR_TMR0_HI    = 8'h8C;
   localparam logic [7:0] SFR_TMR1_HI    = 8'h8D;
   localparam logic [7:0] SFR_PORT1      = 8'h90;
   localparam logic [7:0] SFR_SER_CTRL   = 8'h98;
   localparam logic [7:0] SFR_SER_BUF    = 8'h99;
   localparam logic [7:0] SFR_PORT2      = 8'hA0;
   localparam logic [7:0] SFR_INT_EN     = 8'hA8;
   localparam logic [7:0] SFR_PORT3      = 8'hB0;
   localparam logic [7:0] SFR_INT_PRIO   = 8'hB8;
   localparam logic [7:0] SFR_CRC_LO     = 8'hC2;
   localparam logic [7:0] SFR_CRC_HI     = 8'hC3;
   localparam logic [7:0] SFR_MEM_CTRL   = 8'hC6;
   localparam logic [7:0] SFR_RANDOM     = 8'hCF;
   localparam logic [7:0] SFR_PSWORD     = 8'hD0;
   localparam logic [7:0] SFR_CORE_STAT  = 8'hDA;
   localparam logic [7:0] SFR_ACCUM      = 8'hE0;
   localparam logic [7:0] SFR_BREG       = 8'hF0;

   // Reset values
   localparam logic [7:0]  VAL_ZERO   = 8'h00;
   localparam logic [7:0]  VAL_PORT   = 8'hFF;
   localparam logic [7:0]  VAL_SP     = 8'h07;
   localparam logic [7:0]  VAL_MEMNB  = 8'hF8;
   localparam logic [7:0]  KEEP_ALL   = 8'hFF;
   localparam logic [7:0]  KEEP_NONE  = 8'h00;
   localparam logic [7:0]  KEEP_IEIP  = 8'h60;
   localparam logic [15:0] VAL_PC     = 16'h0000;
   // Power control keep masks and values per reset type
   localparam logic [7:0]  PC_KEEP_EXT = 8'h74;
   localparam logic [7:0]  PC_KEEP_POR = 8'h04;
   localparam logic [7:0]  PC_KEEP_WDT = 8'h44;
   localparam logic [7:0]  PC_VAL_WDT  = 8'h10;

   // Power control fields
   localparam int POR_FLAG_BIT = 6;
   localparam int WDT_FLAG_BIT = 4;
   localparam int WDT_EN_BIT   = 2;
   localparam logic [7:0] PC_TIMED_MASK = 8'h44;
   localparam logic [7:0] PC_RO_MASK    = 8'h10;

   // Timed access key bytes
   localparam logic [7:0] TA_KEY1 = 8'hAA;
   localparam logic [7:0] TA_KEY2 = 8'h55;

   // Interrupt status bit positions
   localparam int IRQ_W       = 4;
   localparam int EV_POWER_ON = 0;
   localparam int EV_EXT      = 1;
   localparam int EV_WDT      = 2;
   localparam int EV_IGNORED  = 3;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Returns {keep mask, load value} for one register and reset type
   function automatic logic [15:0] sfr_reset_rule(input logic [7:0] a, input prs_rst_e t);
      logic [15:0] r;
      r = {KEEP_ALL, VAL_ZERO};
      case (a)
         SFR_PORT0, SFR_PORT1, SFR_PORT2, SFR_PORT3: r = {KEEP_NONE, VAL_PORT};
         SFR_STACK_PTR:                              r = {KEEP_NONE, VAL_SP};
         SFR_INT_EN, SFR_INT_PRIO:                   r = {KEEP_IEIP, VAL_ZERO};
         SFR_DPTR_LO, SFR_DPTR_HI, SFR_ACCUM, SFR_BREG, SFR_PSWORD, SFR_TMR_CTRL,
         SFR_TMR_MODE, SFR_TMR0_LO, SFR_TMR0_HI, SFR_TMR1_LO, SFR_TMR1_HI, SFR_SER_CTRL,
         SFR_CORE_STAT, SFR_CRC_LO, SFR_CRC_HI:     r = {KEEP_NONE, VAL_ZERO};
         SFR_POWER_CTRL: begin
            case (t)
               RT_EXT:   r = {PC_KEEP_EXT, VAL_ZERO};
               RT_POR:   r = {PC_KEEP_POR, VAL_ZERO};
               RT_NOBAT: r = {KEEP_NONE, VAL_ZERO};
               default:  r = {PC_KEEP_WDT, PC_VAL_WDT};
            endcase
         end
         SFR_MEM_CTRL: r = (t == RT_NOBAT) ? {KEEP_NONE, VAL_MEMNB} : {KEEP_ALL, VAL_ZERO};
         default:      r = {KEEP_ALL, VAL_ZERO};
      endcase
      return r;
   endfunction

endpackage

/* prs_sequencer.sv */
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
// Power-on reset sequencer with reset-type register image
module prs_sequencer
   import prs_pkg::*;
#(
   parameter int ADDR_W        = 10,
   parameter int POR_DELAY_CYC = POR_DELAY_PERIODS
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              supply_ok,
   input  wire logic              osc_running,
   input  wire logic              ext_reset_pin,
   input  wire logic              battery_low,
   input  wire logic              wdt_timeout,
   output logic                   internal_reset_line,
   output logic                   irq,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(POR_DELAY_CYC - 1);

   typedef enum logic [2:0] {ST_OFF, ST_OSC, ST_COUNT, ST_EXT, ST_LOAD, ST_RUN} prs_state_e;

   logic [3:0]        pins_s;           // Synchronised pins
   logic              supply_s;         // Supply above threshold
   logic              osc_s;            // Oscillator running
   logic              ext_s;            // External reset held
   logic              batt_s;           // Backup battery low
   prs_state_e        state_r;          // Sequencer state
   logic [CNT_W-1:0]  cnt_r;            // Oscillator period count
   prs_rst_e          rst_type_r;       // Cause applied at load
   logic              internal_reset_line_r;           // Internal reset line
   logic [7:0]        sfr_r [128];      // Register image 80h..FFh
   logic [15:0]       rule_c [128];     // Keep mask and load value per entry
   logic [15:0]       pc_r;             // Program counter image
   logic              ta_stage_r;       // First key byte seen
   logic              ta_open_r;        // Protected bits writable
   logic [IRQ_W-1:0]  irq_stat_r;       // Sticky events
   logic [IRQ_W-1:0]  irq_mask_r;       // Event enables
   logic [IRQ_W-1:0]  ev_c;             // Events this cycle
   logic              irq_r;            // Interrupt output
   logic              aw_full_r;        // Write address held
   logic              w_full_r;         // Write data held
   logic [7:0]        aw_idx_r;         // Held write index
   logic [31:0]       w_data_r;         // Held write data
   logic              w_lane0_r;        // Low byte lane enabled
   logic              awready_r;
   logic              wready_r;
   logic              bvalid_r;
   logic [1:0]        bresp_r;
   logic              arready_r;
   logic              rvalid_r;
   logic [31:0]       rdata_r;
   logic [1:0]        rresp_r;
   logic              wr_fire;          // Both write halves held
   logic              wr_en;            // Write with low lane
   logic              rd_take;          // Read address taken
   logic [7:0]        rd_idx;           // Read index
   logic [31:0]       rd_data_c;        // Read mux data
   logic              rd_ok_c;          // Read index mapped
   logic              wr_ok_c;          // Write index mapped

   // Pins come from outside the clock domain
   prs_sync #(.WIDTH(4)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({battery_low, ext_reset_pin, osc_running, supply_ok}),
      .q       (pins_s)
   );
   assign supply_s = pins_s[0];
   assign osc_s    = pins_s[1];
   assign ext_s    = pins_s[2];
   assign batt_s   = pins_s[3];

   // Reset sequencer; losing supply always returns to the halted state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r    <= ST_OFF;
         cnt_r      <= '0;
         rst_type_r <= RT_POR;
      end else if (!supply_s) begin
         state_r <= ST_OFF;
      end else begin
         case (state_r)
            ST_OFF: state_r <= ST_OSC;
            ST_OSC: begin
               if (osc_s) begin
                  state_r    <= ST_COUNT;
                  cnt_r      <= '0;
                  rst_type_r <= batt_s ? RT_NOBAT : RT_POR;
               end
            end
            ST_COUNT: begin
               if (cnt_r == CNT_LAST) begin
                  state_r <= ST_LOAD;
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            ST_EXT: begin
               if (!ext_s) begin
                  state_r <= ST_LOAD;
               end
            end
            ST_LOAD: state_r <= ST_RUN;
            ST_RUN: begin
               if (ext_s) begin
                  state_r    <= ST_EXT;
                  rst_type_r <= RT_EXT;
               end else if (wdt_timeout) begin
                  state_r    <= ST_LOAD;
                  rst_type_r <= RT_WDT;
               end
            end
            default: state_r <= ST_OFF;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         internal_reset_line_r <= 1'b1;
      end else begin
         internal_reset_line_r <= (state_r != ST_RUN);
      end
   end

   // AXI write channels; address and data accepted in any order
   assign wr_fire = aw_full_r && w_full_r && !bvalid_r;
   assign wr_en   = wr_fire && w_lane0_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         aw_idx_r  <= '0;
         w_data_r  <= '0;
         w_lane0_r <= 1'b0;
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && awready_r) begin
            aw_full_r <= 1'b1;
            aw_idx_r  <= s_axi_awaddr[9:2];
            awready_r <= 1'b0;
         end
         if (s_axi_wvalid && wready_r) begin
            w_full_r  <= 1'b1;
            w_data_r  <= s_axi_wdata;
            w_lane0_r <= s_axi_wstrb[0];
            wready_r  <= 1'b0;
         end
         if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_ok_c ? RESP_OKAY : RESP_SLVERR;
         end
         // Both channels reopen only after the response is taken
         if (bvalid_r && s_axi_bready) begin
            bvalid_r  <= 1'b0;
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
         end
      end
   end

   // Read mux; unmapped indices answer SLVERR with zero data
   assign rd_take = s_axi_arvalid && arready_r;
   assign rd_idx  = s_axi_araddr[9:2];
   assign wr_ok_c = aw_idx_r[7] || (aw_idx_r <= REG_PC_HI);
   always_comb begin
      rd_data_c = '0;
      rd_ok_c   = 1'b1;
      if (rd_idx[7]) begin
         rd_data_c[7:0] = sfr_r[rd_idx[6:0]];
      end else begin
         case (rd_idx)
            REG_IRQ_STATUS: rd_data_c[IRQ_W-1:0] = irq_stat_r;
            REG_IRQ_MASK:   rd_data_c[IRQ_W-1:0] = irq_mask_r;
            REG_SEQ_STATUS: rd_data_c[3:0]       = {ta_open_r, internal_reset_line_r, rst_type_r};
            REG_PC_LO:      rd_data_c[7:0]       = pc_r[7:0];
            REG_PC_HI:      rd_data_c[7:0]       = pc_r[15:8];
            REG_TIMED:      rd_data_c            = '0;
            default:        rd_ok_c              = 1'b0;
         endcase
      end
   end

   // AXI read channel, one read outstanding
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= '0;
         rresp_r   <= RESP_OKAY;
      end else if (rd_take) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rdata_r   <= rd_data_c;
         rresp_r   <= rd_ok_c ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r  <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   // Per-entry reset rule for the cause latched in rst_type_r; a function result cannot be sliced directly
   always_comb begin
      for (int i = 0; i < 128; i++) begin
         rule_c[i] = sfr_reset_rule({1'b1, 7'(i)}, rst_type_r);
      end
   end

   // Register image: reset-type load, then software writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 128; i++) begin
            sfr_r[i] <= VAL_ZERO;
         end
      end else if (state_r == ST_LOAD) begin
         for (int i = 0; i < 128; i++) begin
            sfr_r[i] <= (sfr_r[i] & rule_c[i][15:8]) | rule_c[i][7:0];
         end
      end else begin
         // Writes ignored while the core is held in reset
         if (wr_en && aw_idx_r[7] && !internal_reset_line_r) begin
            if (aw_idx_r == SFR_POWER_CTRL) begin
               sfr_r[aw_idx_r[6:0]] <= (sfr_r[aw_idx_r[6:0]] & (PC_RO_MASK | (ta_open_r ? 8'h00 : PC_TIMED_MASK)))
                  | (w_data_r[7:0] & ~(PC_RO_MASK | (ta_open_r ? 8'h00 : PC_TIMED_MASK)));
            end else begin
               sfr_r[aw_idx_r[6:0]] <= w_data_r[7:0];
            end
         end
         // Watchdog flag clears when power control is read
         if (rd_take && rd_idx == SFR_POWER_CTRL) begin
            sfr_r[SFR_POWER_CTRL[6:0]][WDT_FLAG_BIT] <= 1'b0;
         end
      end
   end

   // Program counter image, zero on every reset
   always_ff @(posedge aclk) begin
      if (!aresetn || state_r == ST_LOAD) begin
         pc_r <= VAL_PC;
      end else if (wr_en && !internal_reset_line_r && aw_idx_r == REG_PC_LO) begin
         pc_r[7:0] <= w_data_r[7:0];
      end else if (wr_en && !internal_reset_line_r && aw_idx_r == REG_PC_HI) begin
         pc_r[15:8] <= w_data_r[7:0];
      end
   end

   // Timed access: two key bytes open one protected write
   always_ff @(posedge aclk) begin
      if (!aresetn || state_r == ST_LOAD) begin
         ta_stage_r <= 1'b0;
         ta_open_r  <= 1'b0;
      end else if (wr_en) begin
         ta_stage_r <= (aw_idx_r == REG_TIMED) && (w_data_r[7:0] == TA_KEY1);
         ta_open_r  <= (aw_idx_r == REG_TIMED) && (w_data_r[7:0] == TA_KEY2) && ta_stage_r;
      end
   end

   // Events for the interrupt status
   always_comb begin
      ev_c              = '0;
      ev_c[EV_POWER_ON] = (state_r == ST_LOAD) && (rst_type_r == RT_POR || rst_type_r == RT_NOBAT);
      ev_c[EV_EXT]      = (state_r == ST_LOAD) && (rst_type_r == RT_EXT);
      ev_c[EV_WDT]      = (state_r == ST_LOAD) && (rst_type_r == RT_WDT);
      ev_c[EV_IGNORED]  = ext_s && supply_s && (state_r == ST_OSC || state_r == ST_COUNT);
   end

   // Sticky status with write-one-to-clear; a new event beats the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_r <= '0;
         irq_mask_r <= '0;
         irq_r      <= 1'b0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~((wr_en && aw_idx_r == REG_IRQ_STATUS) ? w_data_r[IRQ_W-1:0] : '0)) | ev_c;
         if (wr_en && aw_idx_r == REG_IRQ_MASK) begin
            irq_mask_r <= w_data_r[IRQ_W-1:0];
         end
         irq_r <= |(irq_stat_r & irq_mask_r);
      end
   end

   assign internal_reset_line = internal_reset_line_r;
   assign irq                 = irq_r;
   assign s_axi_awready       = awready_r;
   assign s_axi_wready        = wready_r;
   assign s_axi_bvalid        = bvalid_r;
   assign s_axi_bresp         = bresp_r;
   assign s_axi_arready       = arready_r;
   assign s_axi_rvalid        = rvalid_r;
   assign s_axi_rdata         = rdata_r;
   assign s_axi_rresp         = rresp_r;

   por_count_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_r == ST_COUNT && cnt_r == CNT_LAST && supply_s) |=> state_r == ST_LOAD)
      else $error("count end did not start load");
   por_count_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_r == ST_COUNT && cnt_r != CNT_LAST && supply_s) |=> state_r == ST_COUNT)
      else $error("count left early");
   pin_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_r inside {ST_OSC, ST_COUNT}) |=> state_r != ST_EXT)
      else $error("external pin acted during power-on");
   pin_accepted_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_r == ST_RUN && supply_s && ext_s) |=> state_r == ST_EXT ##1 internal_reset_line_r)
      else $error("external pin not accepted");
   por_flag_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_r == ST_LOAD && rst_type_r == RT_POR) |=> !sfr_r[SFR_POWER_CTRL[6:0]][POR_FLAG_BIT])
      else $error("power-on flag not cleared");
   por_keep_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_r == ST_LOAD && rst_type_r == RT_POR)
      |=> sfr_r[SFR_POWER_CTRL[6:0]][WDT_EN_BIT] == $past(sfr_r[SFR_POWER_CTRL[6:0]][WDT_EN_BIT])
          && sfr_r[SFR_MEM_CTRL[6:0]] == $past(sfr_r[SFR_MEM_CTRL[6:0]]))
      else $error("power-on changed retained bits");
   core_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_r == ST_LOAD) |=> sfr_r[SFR_STACK_PTR[6:0]] == VAL_SP && sfr_r[SFR_PORT2[6:0]] == VAL_PORT
          && pc_r == VAL_PC && sfr_r[SFR_INT_EN[6:0]][4:0] == 5'h00)
      else $error("core registers not loaded");
   wdt_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_r == ST_LOAD && rst_type_r == RT_WDT)
      |=> sfr_r[SFR_POWER_CTRL[6:0]][WDT_FLAG_BIT] && !sfr_r[SFR_POWER_CTRL[6:0]][5])
      else $error("watchdog load wrong");
   accum_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_r == ST_LOAD) |=> sfr_r[SFR_ACCUM[6:0]] == VAL_ZERO && sfr_r[SFR_CRC_HI[6:0]] == VAL_ZERO
          && sfr_r[SFR_SER_BUF[6:0]] == $past(sfr_r[SFR_SER_BUF[6:0]]))
      else $error("core registers not cleared");
   reset_held_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_r != ST_RUN) |=> internal_reset_line_r)
      else $error("internal reset dropped early");
   release_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(internal_reset_line_r) |-> $past(state_r, 2) == ST_LOAD)
      else $error("release not after load");
   nobat_mem_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_r == ST_LOAD && rst_type_r == RT_NOBAT) |=> sfr_r[SFR_MEM_CTRL[6:0]] == VAL_MEMNB)
      else $error("memory control not loaded");
   type_stable_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_r == ST_LOAD) |=> rst_type_r == $past(rst_type_r))
      else $error("reset type changed at load");
endmodule

/* prs_supply_model.sv */
`timescale 1ns/1ps
// Supply monitor, crystal and external reset pin facing the core
module prs_supply_model #(
   parameter int OSC_DLY = 5
) (
   input  wire logic aclk,
   input  wire logic pwr_on,
   input  wire logic pin_req,
   input  wire logic bat_req,
   output logic      supply_ok = 1'b0,
   output logic      osc_running = 1'b0,
   output logic      ext_reset_pin = 1'b0,
   output logic      battery_low = 1'b0
);
   int osc_cnt = 0; // Mechanical crystal start-up time
   // crystal halted while supply is low
   always @(posedge aclk) begin
      supply_ok <= pwr_on;
      battery_low <= bat_req;
      ext_reset_pin <= pin_req;
      osc_cnt <= pwr_on ? ((osc_cnt < OSC_DLY) ? osc_cnt + 1 : osc_cnt) : 0;
      osc_running <= pwr_on && (osc_cnt == OSC_DLY);
   end
endmodule

/* prs_sync.sv */
`timescale 1ns/1ps
// Two-flop synchroniser for pin inputs
module prs_sync #(
   parameter int WIDTH = 4
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;   // First stage, read only by second stage
   logic [WIDTH-1:0] q_r;      // Second stage, safe to use

   // Plain double flop; pins are slow levels so no handshake needed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= '0;
         q_r    <= '0;
      end else begin
         meta_r <= d;
         q_r    <= meta_r;
      end
   end

   assign q = q_r;
endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb;
   import prs_pkg::*;
   localparam int DLY = 16;
   logic aclk = 0, aresetn = 0, pwr_on = 0, pin_req = 0, bat_req = 0, wdt_timeout = 0;
   logic supply_ok, osc_running, ext_reset_pin, battery_low, internal_reset_line, irq;
   logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs, bs;
   logic [7:0] v;
   int fail_count = 0, n_tests = 0, seed = 32'hd928, k;
   // Image entries with a fixed load value on any reset
   logic [7:0] ra [6] = '{SFR_STACK_PTR, SFR_PORT0, SFR_PORT3, SFR_ACCUM, SFR_DPTR_HI, SFR_CRC_LO};
   logic [7:0] rv [6] = '{8'h07, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
   always #20 aclk = ~aclk;
   prs_supply_model mdl (.*);
   prs_sequencer #(.POR_DELAY_CYC(DLY)) dut (.*);
   // Power control after a reset of cause t: ext, por, no battery, watchdog
   function automatic logic [7:0] pc_exp(input int t, input logic [7:0] old);
      logic [7:0] keep [4] = '{8'h74, 8'h04, 8'h00, 8'h44};
      return (old & keep[t]) | ((t == 3) ? 8'h10 : 8'h00);
   endfunction
   task automatic end_sim();
      $display("mismatches %0d checks %0d", fail_count, n_tests);
      if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // Every wait is bounded; running out ends the run as a mismatch
   task automatic hang();
      if (k >= 200) begin
         chk("timeout", 0, 1);
         end_sim();
      end
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      @(posedge aclk);
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= ($random(seed) << 8) | d; // Upper bits must be ignored
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      for (k = 0; k < 200; k++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_bvalid) break;
      end
      hang();
      bs = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task automatic rdr(input logic [7:0] i);
      @(posedge aclk);
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      for (k = 0; k < 200; k++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
         if (s_axi_rvalid) break;
      end
      hang();
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
   // Waits for the crystal, then for release; optional pin pulse meanwhile
   task automatic por(input logic pulse);
      for (k = 0; k < 200 && osc_running !== 1'b1; k++) @(posedge aclk);
      hang();
      for (k = 0; k < 200 && internal_reset_line !== 1'b0; k++) begin
         @(posedge aclk);
         pin_req <= pulse && k >= 2 && k < 5;
      end
      hang();
   endtask
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      pwr_on <= 1;
      por(1);
      chk("por_delay", k >= DLY && k <= DLY + 8, 1);
      rdr(REG_SEQ_STATUS);
      chk("seq_status", rd, 32'h1);
      rdr(REG_IRQ_STATUS);
      chk("irq_status", rd, 32'h9);
      wr(REG_IRQ_MASK, 8'h09);
      repeat (3) @(posedge aclk);
      chk("irq_on", irq, 1);
      wr(REG_IRQ_STATUS, 8'h09);
      repeat (3) @(posedge aclk);
      chk("irq_off", irq, 0);
      // software sets the power-on flag by timed access
      wr(REG_TIMED, TA_KEY1);
      wr(REG_TIMED, TA_KEY2);
      wr(SFR_POWER_CTRL, 8'h44);
      chk("ta_bresp", bs, RESP_OKAY);
      v = $random(seed);
      foreach (ra[j]) wr(ra[j], v);
      wr(SFR_INT_EN, v);
      wr(SFR_SER_BUF, v);
      pin_req <= 1;
      repeat (6) @(posedge aclk);
      chk("internal_reset_line_held", internal_reset_line, 1);
      pin_req <= 0;
      por(0);
      foreach (ra[j]) begin
         rdr(ra[j]);
         chk("image", rd, {24'h0, rv[j]});
      end
      rdr(SFR_INT_EN);
      chk("int_en", rd, {24'h0, v & 8'h60});
      rdr(SFR_SER_BUF);
      chk("ser_buf", rd, {24'h0, v});
      rdr(SFR_POWER_CTRL);
      chk("pc_ext", rd, {24'h0, pc_exp(0, 8'h44)});
      // Without the key the protected bits must not move
      wr(SFR_POWER_CTRL, 8'h00);
      rdr(SFR_POWER_CTRL);
      chk("pc_locked", rd, 32'h44);
      @(posedge aclk);
      wdt_timeout <= 1;
      @(posedge aclk);
      wdt_timeout <= 0;
      repeat (6) @(posedge aclk);
      rdr(SFR_POWER_CTRL);
      chk("pc_wdt", rd, {24'h0, pc_exp(3, 8'h44)});
      rdr(SFR_POWER_CTRL);
      chk("pc_rdclr", rd, 32'h44);
      rdr(REG_IRQ_STATUS);
      chk("irq_ext_wdt", rd, 32'h6);
      bat_req <= 1;
      pwr_on <= 0;
      repeat (6) @(posedge aclk);
      chk("internal_reset_line_off", internal_reset_line, 1);
      pwr_on <= 1;
      por(1);
      rdr(SFR_MEM_CTRL);
      chk("mem_nobat", rd, 32'hF8);
      rdr(SFR_POWER_CTRL);
      chk("pc_nobat", rd, {24'h0, pc_exp(2, 8'h44)});
      rdr(8'h06);
      chk("unmapped", rs, RESP_SLVERR);
      end_sim();
   end
endmodule
